// ===== rtl/pobl_pkg.sv
`default_nettype none
package pobl_pkg;
  // Leading edge blanking time, nanoseconds
  localparam int LEB_TIME_NS   = 375;
  // Block clock period, nanoseconds
  localparam int CLK_PERIOD_NS = 5;
  // Blanking count, rounded up, at least one cycle
  localparam int LEB_CYCLES    = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the blanking counter
  localparam int LEB_CNT_W     = 8;
  // Output variant selection
  localparam logic MODE_IN_PHASE    = 1'h0;
  localparam logic MODE_ALTERNATING = 1'h1;
  // Fault sequencing states, Gray coded along the usual path
  typedef enum logic [1:0] {
    POBL_RUN    = 2'h0,
    POBL_CHARGE = 2'h1,
    POBL_DRAIN  = 2'h3,
    POBL_WAIT   = 2'h2
  } pobl_fault_e;
endpackage : pobl_pkg
`default_nettype wire

// ===== rtl/pobl_core.sv
// Operation
// - In-phase mode: both outputs pulse every period
// - Alternating mode: outputs take turns, half rate
// - Both outputs low during clock pulse
// - Pulse starts at clock pulse falling edge
// - First of three comparators ends pulse
// - PWM comparator trip ends the pulse
// - PWM comparator ignored during blanking interval
// - Current limit blanked, then ends pulse
// - Overcurrent never blanked, latches fault, outputs low
// - No output high during ramp fall
// - Fault clears after soft-start empty, sense low
// - Fault during soft-start waits for full charge
// - Lockout holds outputs low until supplies valid
`default_nettype none
module pobl_core
  import pobl_pkg::*;
#(
  parameter logic [LEB_CNT_W-1:0] BLANK_CYCLES = LEB_CNT_W'(LEB_CYCLES)
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Configuration
  input  wire logic outputMode,
  // Oscillator timing
  input  wire logic clockPulse,
  // Comparator results
  input  wire logic pwmTrip,
  input  wire logic currentLimitTrip,
  input  wire logic overcurrentTrip,
  // Supervisor and soft-start status
  input  wire logic undervoltageLockout,
  input  wire logic softStartFull,
  input  wire logic softStartEmpty,
  // Gate drive outputs
  output logic      gateA,
  output logic      gateB,
  // Status
  output logic      faultLatched,
  output logic      softStartDischarge,
  output logic      softStartRestart
);

  ////////////////////////////////////////////////////////////////
  // State
  logic                 clockPulseDly;     // Previous clock pulse level
  logic                 steer;             // Alternating output pointer
  logic                 pulseOn;           // Pulse currently active
  logic [LEB_CNT_W-1:0] blankCnt;          // Remaining blanked cycles
  pobl_fault_e          faultState;        // Fault sequencer
  logic                 next_gateA;
  logic                 next_gateB;
  logic                 next_steer;
  logic                 next_pulseOn;
  logic [LEB_CNT_W-1:0] next_blankCnt;
  pobl_fault_e          next_faultState;
  logic                 next_restart;
  logic                 next_faultLatched;       // Latch state for the coming cycle
  logic                 next_softStartDischarge; // Discharge request for the coming cycle

  // Start strobe: falling edge of clock pulse
  logic pulseStart;
  logic blanked;
  logic inhibit;
  assign pulseStart = clockPulseDly && !clockPulse;
  assign blanked    = blankCnt != '0;
  // Anything that forbids a pulse right now
  assign inhibit    = undervoltageLockout || overcurrentTrip
                      || faultState != POBL_RUN;

  ////////////////////////////////////////////////////////////////
  // Pulse next-state logic
  always_comb
  begin
    next_pulseOn  = pulseOn;
    next_steer    = steer;
    next_blankCnt = blanked ? blankCnt - 1'h1 : blankCnt;
    if (inhibit || clockPulse)
    begin
      // Clock pulse is the dead time; fault and lockout kill at once
      next_pulseOn  = 1'h0;
      next_blankCnt = '0;
    end
    else if (pulseStart)
    begin
      // New cycle: start pulse, arm blanking, flip steering
      next_pulseOn  = 1'h1;
      next_blankCnt = BLANK_CYCLES;
      next_steer    = !steer;
    end
    else if (pulseOn && !blanked && (pwmTrip || currentLimitTrip))
    begin
      // PWM and current limit comparators only count once blanking is over
      next_pulseOn = 1'h0;
    end
    // Output steering per variant
    if (outputMode == MODE_ALTERNATING)
    begin
      next_gateA = next_pulseOn && next_steer;
      next_gateB = next_pulseOn && !next_steer;
    end
    else
    begin
      next_gateA = next_pulseOn;
      next_gateB = next_pulseOn;
    end
  end

  // Pulse registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clockPulseDly <= 1'h1;
      steer         <= 1'h0;
      pulseOn       <= 1'h0;
      blankCnt      <= '0;
      gateA         <= 1'h0;
      gateB         <= 1'h0;
    end
    else
    begin
      clockPulseDly <= clockPulse;
      steer         <= next_steer;
      pulseOn       <= next_pulseOn;
      blankCnt      <= next_blankCnt;
      gateA         <= next_gateA;
      gateB         <= next_gateB;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Fault sequencer next state
  always_comb
  begin
    next_faultState = faultState;
    next_restart    = 1'h0;
    case (faultState)
      POBL_RUN:
        // Overcurrent latches; wait for full charge if still ramping
        if (overcurrentTrip)
          next_faultState = softStartFull ? POBL_DRAIN : POBL_CHARGE;
      POBL_CHARGE:
        if (softStartFull)
          next_faultState = POBL_DRAIN;
      POBL_DRAIN:
        if (softStartEmpty)
          next_faultState = POBL_WAIT;
      POBL_WAIT:
        // Sense must fall below the overcurrent level before restart
        if (!overcurrentTrip)
        begin
          next_faultState = POBL_RUN;
          next_restart    = 1'h1;
        end
      default:
        next_faultState = POBL_RUN;
    endcase
    // Status flags are registered so the gate driver sees no decode glitches
    next_faultLatched       = next_faultState != POBL_RUN;
    next_softStartDischarge = next_faultState == POBL_DRAIN;
  end

  // Fault registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      faultState         <= POBL_RUN;
      softStartRestart   <= 1'h0;
      faultLatched       <= 1'h0;
      softStartDischarge <= 1'h0;
    end
    else
    begin
      faultState         <= next_faultState;
      softStartRestart   <= next_restart;
      faultLatched       <= next_faultLatched;
      softStartDischarge <= next_softStartDischarge;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  dead_time_a: assert property (@(posedge clk) disable iff (rst)
    $past(clockPulse) |-> !gateA && !gateB)
    else $error("gate high during clock pulse");
  start_edge_a: assert property (@(posedge clk) disable iff (rst)
    $fell(clockPulse) && !inhibit |=> gateA || gateB)
    else $error("no pulse after clock fall");
  over_kill_a: assert property (@(posedge clk) disable iff (rst)
    overcurrentTrip |=> !gateA && !gateB && faultLatched)
    else $error("overcurrent did not kill outputs");
  blank_pwm_a: assert property (@(posedge clk) disable iff (rst)
    $fell(clockPulse) && !inhibit ##1 (!clockPulse && !inhibit)[*2] |-> pulseOn)
    else $error("pulse ended inside blanking");
  pwm_end_a: assert property (@(posedge clk) disable iff (rst)
    pulseOn && !blanked && pwmTrip && !pulseStart |=> !pulseOn)
    else $error("pwm trip ignored");
  alt_excl_a: assert property (@(posedge clk) disable iff (rst)
    outputMode == MODE_ALTERNATING |-> !(gateA && gateB))
    else $error("both gates high in alternating mode");
  lockout_low_a: assert property (@(posedge clk) disable iff (rst)
    undervoltageLockout |=> !gateA && !gateB)
    else $error("gate high under lockout");
  charge_first_a: assert property (@(posedge clk) disable iff (rst)
    faultState == POBL_CHARGE && !softStartFull |=> !softStartDischarge)
    else $error("discharge before full charge");
  restart_a: assert property (@(posedge clk) disable iff (rst)
    faultState == POBL_WAIT && !overcurrentTrip |=> softStartRestart && !faultLatched)
    else $error("fault not released");
  cov_pulse_c:   cover property (@(posedge clk) $rose(gateA));
  cov_fault_c:   cover property (@(posedge clk) $rose(faultLatched));
  in_phase_a: assert property (@(posedge clk) disable iff (rst)
    outputMode == MODE_IN_PHASE |-> gateA == gateB)
    else $error("gates differ in in-phase mode");
  cov_restart_c: cover property (@(posedge clk) softStartRestart);
  cov_alt_b_c:   cover property (@(posedge clk) $rose(gateB) && !gateA);

endmodule : pobl_core
`default_nettype wire

// ===== dv/pobl_sense_model.sv
`default_nettype none
// Switch and sense network: current flows only while a gate conducts
module pobl_sense_model
(
  // Gate drive
  input  wire logic       gateA,
  input  wire logic       gateB,
  // Sense level: 1 above limit, 2 above overcurrent
  input  wire logic [1:0] senseCmd,
  // Comparators
  output logic            currentLimitTrip,
  output logic            overcurrentTrip
);
  timeunit 1ns;
  timeprecision 100ps;
  // No conduction, no current, so both comparators fall
  assign currentLimitTrip = (senseCmd != 2'h0) & (gateA | gateB);
  assign overcurrentTrip  = senseCmd[1] & (gateA | gateB);
endmodule : pobl_sense_model
`default_nettype wire

// ===== dv/pobl_core_bench.sv
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module pobl_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Short blanking keeps the run brief
  localparam logic [7:0] BLANK = 8'h03;
  logic clk = 1'h0, rst = 1'h1, clockPulse = 1'h1, pwmTrip = 1'h0;
  logic outputMode = pobl_pkg::MODE_ALTERNATING;
  logic undervoltageLockout = 1'h0, softStartFull = 1'h0, softStartEmpty = 1'h0;
  logic [1:0] senseCmd = 2'h0;
  wire logic currentLimitTrip, overcurrentTrip, gateA, gateB;
  wire logic faultLatched, softStartDischarge, softStartRestart;
  int fail_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  pobl_core #(.BLANK_CYCLES(BLANK)) pobl_core_i (.clk(clk), .rst(rst),
    .outputMode(outputMode), .clockPulse(clockPulse), .pwmTrip(pwmTrip),
    .currentLimitTrip(currentLimitTrip), .overcurrentTrip(overcurrentTrip),
    .undervoltageLockout(undervoltageLockout), .softStartFull(softStartFull),
    .softStartEmpty(softStartEmpty), .gateA(gateA), .gateB(gateB),
    .faultLatched(faultLatched), .softStartDischarge(softStartDischarge),
    .softStartRestart(softStartRestart));
  pobl_sense_model pobl_sense_model_i (.gateA(gateA), .gateB(gateB), .senseCmd(senseCmd),
    .currentLimitTrip(currentLimitTrip), .overcurrentTrip(overcurrentTrip));
  ////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
  endtask : tick
  // Verdict and end of run
  task automatic complete_run;
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // Low phase, dead time, release; returns at the edge that starts the pulse
  task automatic start_period;
    // Five low samples to two high keep the duty limit above 70 percent
    repeat (4) tick;
    clockPulse <= 1'h1;
    tick;
    #1 `CHK("dead gates", 1'h0, gateA | gateB);
    tick;
    clockPulse <= 1'h0;
    tick;
  endtask : start_period
  // Steering flips each period, A first
  task automatic alt_test;
    start_period();
    #1 `CHK("alt A on", 2'h2, {gateA, gateB});
    start_period();
    #1 `CHK("alt B on", 2'h1, {gateA, gateB});
  endtask : alt_test
  // Trip held from the start: ignored while blanked, then ends pulse
  task automatic blank_test(input logic viaLimit);
    start_period();
    pwmTrip <= !viaLimit;
    senseCmd <= {1'h0, viaLimit};
    #1 `CHK("both on", 2'h3, {gateA, gateB});
    repeat (int'(BLANK))
    begin
      tick;
      #1 `CHK("blanked", 1'b1, gateA);
    end
    tick;
    #1 `CHK("ended", 2'h0, {gateA, gateB});
    tick;
    pwmTrip <= 1'h0;
    senseCmd <= 2'h0;
  endtask : blank_test
  // Overcurrent hits at once, waits for full charge, drains, restarts
  task automatic fault_test;
    logic seen;
    seen = 1'h0;
    start_period();
    senseCmd <= 2'h2;
    tick;
    #1 `CHK("oc latch", 3'h1, {gateA, gateB, faultLatched});
    start_period();
    #1 `CHK("held off", 3'h0, {gateA, gateB, softStartDischarge});
    tick;
    softStartFull <= 1'h1;
    repeat (2) tick;
    #1 `CHK("drain", 1'h1, softStartDischarge);
    tick;
    softStartFull <= 1'h0;
    softStartEmpty <= 1'h1;
    // Bounded wait for the restart pulse
    repeat (10)
    begin
      tick;
      #1 if (softStartRestart === 1'h1) seen = 1'h1;
    end
    `CHK("restart", 2'h2, {seen, faultLatched});
    if (!seen) complete_run();
    tick;
    softStartEmpty <= 1'h0;
    senseCmd <= 2'h0;
  endtask : fault_test
  // Lockout kills a live pulse, blocks the next, release lets pulses through
  task automatic lockout_test;
    start_period();
    undervoltageLockout <= 1'h1;
    tick;
    #1 `CHK("lockout kill", 2'h0, {gateA, gateB});
    start_period();
    #1 `CHK("lockout", 2'h0, {gateA, gateB});
    tick;
    undervoltageLockout <= 1'h0;
    start_period();
    #1 `CHK("unlocked", 2'h3, {gateA, gateB});
  endtask : lockout_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) tick;
    rst <= 1'h0;
    alt_test();
    // Mode is static, so change it under reset, on a clock edge
    tick;
    outputMode <= pobl_pkg::MODE_IN_PHASE;
    rst <= 1'h1;
    repeat (8) tick;
    rst <= 1'h0;
    blank_test(1'b0);
    blank_test(1'b1);
    fault_test();
    lockout_test();
    complete_run();
  end
endmodule : pobl_core_bench
`default_nettype wire
